// [i2c_status_and_address_mask_test.sv]
// Purpose: Self-checking bench of the status and mask block.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes: Random values come from a fixed-seed shift register.
`timescale 1ns/10ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module i2c_status_and_address_mask_test;
    import isam_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte, tx_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic start_det, stop_det, addr_byte_stb, addr_rw, rx_byte_stb, tx_done, addr_cmp_stb;
    logic tx_load, addr_match, rx_buffer_full_flag, tx_buffer_full_flag, irq;
    logic [9:0] addr_cmp, own, msk, inc;
    logic e_st, e_rw, e_rx, e_tx;
    int n_errors, n_compared;
    isam_top isam_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_det, .stop_det, .addr_byte_stb,
        .addr_rw, .rx_byte_stb, .rx_byte, .tx_done, .addr_cmp_stb, .addr_cmp, .tx_load,
        .tx_byte, .addr_match, .rx_buffer_full_flag, .tx_buffer_full_flag, .irq);
    isam_bus_agent isam_bus_agent_i (.aclk, .start_det, .stop_det, .addr_byte_stb, .addr_rw,
        .rx_byte_stb, .rx_byte, .tx_done, .addr_cmp_stb, .addr_cmp);
    // --------
    // Helpers
    // --------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic exp_match(input logic [9:0] a, o, m);
        return ((a ^ o) & ~m) == 10'h000;
    endfunction : exp_match
    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic hang();
        n_errors++;
        print_verdict();
    endtask : hang
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_bvalid) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (i == 100) hang();
        `CHK(s_axi_bresp, er)
    endtask : axi_wr
    task automatic axi_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_rvalid) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (i == 100) hang();
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
        #1;
    endtask : axi_chk
    task automatic chk_status();
        axi_chk(OFF_BUS_STATUS, {28'h0000000, e_st, e_rw, e_rx, e_tx}, RESP_OKAY);
    endtask : chk_status
    // --------
    // Clock and stimulus
    // --------
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {e_st, e_rw, e_rx, e_tx} = 4'h0;
        n_errors = 0;
        n_compared = 0;
        seed = 32'h00004CD1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_chk(OFF_SLAVE_ADDRESS_MASK, 32'h00000000, RESP_OKAY);
        chk_status();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            axi_wr(OFF_SLAVE_ADDRESS_MASK, seed, RESP_OKAY);
            axi_chk(OFF_SLAVE_ADDRESS_MASK, seed & 32'h000003FF, RESP_OKAY);
        end
        axi_wr(8'h40, seed, RESP_SLVERR);
        axi_chk(8'h40, 32'h00000000, RESP_SLVERR);
        for (int k = 0; k < 3; k++) begin
            isam_bus_agent_i.ev(k % 2, 10'h000);
            e_st = (k % 2 == 0);
            chk_status();
        end
        isam_bus_agent_i.ev(0, 10'h000);
        chk_status();
        for (int k = 1; k >= 0; k--) begin
            isam_bus_agent_i.ev(2, 10'(k));
            e_rw = k[0];
            chk_status();
        end
        seed = lfsr(seed);
        isam_bus_agent_i.ev(3, seed[9:0]);
        e_rx = 1'b1;
        `CHK(rx_buffer_full_flag, 1'b1)
        axi_wr(OFF_BUS_STATUS, 32'h00000000, RESP_OKAY);
        chk_status();
        axi_chk(OFF_RECEIVE_DATA, {24'h000000, seed[7:0]}, RESP_OKAY);
        e_rx = 1'b0;
        `CHK(rx_buffer_full_flag, 1'b0)
        seed = lfsr(seed);
        axi_wr(OFF_TRANSMIT_DATA, seed, RESP_OKAY);
        e_tx = 1'b1;
        chk_status();
        `CHK(tx_byte, seed[7:0])
        isam_bus_agent_i.ev(4, 10'h000);
        e_tx = 1'b0;
        chk_status();
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            own = seed[9:0];
            msk = (i < 2) ? 10'h000 : ((i == 2) ? 10'h3FF : seed[19:10]);
            inc = i[0] ? (own ^ seed[29:20]) : (own ^ (seed[29:20] & msk));
            axi_wr(OFF_OWN_ADDRESS, {22'h000000, own}, RESP_OKAY);
            axi_wr(OFF_SLAVE_ADDRESS_MASK, {22'h000000, msk}, RESP_OKAY);
            isam_bus_agent_i.ev(5, inc);
            `CHK(addr_match, exp_match(inc, own, msk))
        end
        axi_wr(OFF_IRQ_MASK, 32'h00000004, RESP_OKAY);
        axi_chk(OFF_IRQ_STATUS, 32'h0000001F, RESP_OKAY);
        `CHK(irq, 1'b0)
        isam_bus_agent_i.ev(3, 10'h05A);
        `CHK(irq, 1'b1)
        axi_chk(OFF_IRQ_STATUS, 32'h00000004, RESP_OKAY);
        `CHK(irq, 1'b0)
        isam_bus_agent_i.ev(0, 10'h000);
        `CHK(irq, 1'b0)
        axi_chk(OFF_IRQ_STATUS, 32'h00000001, RESP_OKAY);
        print_verdict();
    end
endmodule : i2c_status_and_address_mask_test

// [isam_addr_match.sv]
// Purpose: Masked comparison of an incoming ten-bit address with the own address.
// Assumes: Inputs are stable while compared.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module isam_addr_match (
    input wire logic [isam_pkg::MASK_W-1:0] incoming,
    input wire logic [isam_pkg::MASK_W-1:0] own_address,
    input wire logic [isam_pkg::MASK_W-1:0] address_bit_mask,
    output logic match
);
    import isam_pkg::*;

    logic [MASK_W-1:0] bit_ok;

    for (genvar i = 0; i < MASK_W; i++) begin : g_bit
        assign bit_ok[i] = address_bit_mask[i] | (incoming[i] == own_address[i]);
    end

    assign match = &bit_ok;
endmodule : isam_addr_match

// [isam_bus_agent.sv]
// Purpose: Far-side bus agent that raises bus engine events.
// Assumes: Each event is a one-cycle pulse after a rising edge.
// Notes: Data lines show the inverse once a pulse ends.
`timescale 1ns/10ps
module isam_bus_agent (
    input wire logic aclk,
    output logic start_det,
    output logic stop_det,
    output logic addr_byte_stb,
    output logic addr_rw,
    output logic rx_byte_stb,
    output logic [isam_pkg::BYTE_W-1:0] rx_byte,
    output logic tx_done,
    output logic addr_cmp_stb,
    output logic [isam_pkg::MASK_W-1:0] addr_cmp
);
    import isam_pkg::*;
    // --------
    // Event launcher
    // --------
    initial begin
        {start_det, stop_det, addr_byte_stb, addr_rw, rx_byte_stb, tx_done, addr_cmp_stb} = '0;
        rx_byte = 8'h00;
        addr_cmp = 10'h000;
    end
    // Kind 0 start, 1 stop, 2 address byte, 3 received byte, 4 sent, 5 compare.
    task automatic ev(input int k, input logic [9:0] v);
        @(posedge aclk);
        start_det <= (k == 0);
        stop_det <= (k == 1);
        addr_byte_stb <= (k == 2);
        addr_rw <= v[0];
        rx_byte_stb <= (k == 3);
        rx_byte <= v[7:0];
        tx_done <= (k == 4);
        addr_cmp_stb <= (k == 5);
        addr_cmp <= v;
        @(posedge aclk);
        {start_det, stop_det, addr_byte_stb, rx_byte_stb, tx_done, addr_cmp_stb} <= '0;
        addr_rw <= ~v[0];
        rx_byte <= ~v[7:0];
        addr_cmp <= ~v;
        #1;
    endtask : ev
endmodule : isam_bus_agent

// [isam_pkg.sv]
// Purpose: Shared constants for the two-wire status and address mask block.
// Assumes: AXI4-Lite with 32-bit data and byte addresses in the low 8 bits.
// Notes: Every offset, field position and response code lives here, with the reset values of the mask, address, byte and interrupt registers.
package isam_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int MASK_W = 10;
    localparam int BYTE_W = 8;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_BUS_STATUS = 8'h00;
    localparam logic [7:0] OFF_SLAVE_ADDRESS_MASK = 8'h04;
    localparam logic [7:0] OFF_RECEIVE_DATA = 8'h08;
    localparam logic [7:0] OFF_TRANSMIT_DATA = 8'h0C;
    localparam logic [7:0] OFF_OWN_ADDRESS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // ------------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------------
    localparam int BIT_TX_FULL = 0;
    localparam int BIT_RX_FULL = 1;
    localparam int BIT_READ_WRITE = 2;
    localparam int BIT_START = 3;

    // ------------------------------------------------------------------
    // Interrupt event positions
    // ------------------------------------------------------------------
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_RX = 2;
    localparam int IRQ_TX_DONE = 3;
    localparam int IRQ_MATCH = 4;
    localparam int IRQ_W = 5;

    // ------------------------------------------------------------------
    // Reset values and responses
    // ------------------------------------------------------------------
    localparam logic [9:0] RST_MASK = 10'h000;
    localparam logic [9:0] RST_OWN_ADDRESS = 10'h000;
    localparam logic [4:0] RST_IRQ = 5'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : isam_pkg

// [isam_status_flags.sv]
// Purpose: Start, direction, receive-full and transmit-full status flags.
// Assumes: All event inputs are one-cycle pulses, from the bus engine except rx_read and tx_write from the register port.
// Notes: A set that meets a clear in the same cycle wins.
`timescale 1ns/10ps
module isam_status_flags (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start_det,
    input wire logic stop_det,
    input wire logic addr_byte_stb,
    input wire logic addr_rw,
    input wire logic rx_byte_stb,
    input wire logic rx_read,
    input wire logic tx_write,
    input wire logic tx_done,
    output logic start_flag,
    output logic read_write_flag,
    output logic rx_buffer_full_flag,
    output logic tx_buffer_full_flag
);
    import isam_pkg::*;

    logic next_start_flag;
    logic next_read_write_flag;
    logic next_rx_buffer_full_flag;
    logic next_tx_buffer_full_flag;

    // ------------------------------------------------------------------
    // Flag update
    // ------------------------------------------------------------------
    always_comb begin
        next_start_flag = start_flag;
        if (start_det) begin
            next_start_flag = 1'b1;
        end else if (stop_det) begin
            next_start_flag = 1'b0;
        end
        next_read_write_flag = read_write_flag;
        if (addr_byte_stb) begin
            next_read_write_flag = addr_rw;
        end
        next_rx_buffer_full_flag = rx_buffer_full_flag;
        if (rx_byte_stb) begin
            next_rx_buffer_full_flag = 1'b1;
        end else if (rx_read) begin
            next_rx_buffer_full_flag = 1'b0;
        end
        next_tx_buffer_full_flag = tx_buffer_full_flag;
        if (tx_write) begin
            next_tx_buffer_full_flag = 1'b1;
        end else if (tx_done) begin
            next_tx_buffer_full_flag = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_flag <= 1'b0;
            read_write_flag <= 1'b0;
            rx_buffer_full_flag <= 1'b0;
            tx_buffer_full_flag <= 1'b0;
        end else begin
            start_flag <= next_start_flag;
            read_write_flag <= next_read_write_flag;
            rx_buffer_full_flag <= next_rx_buffer_full_flag;
            tx_buffer_full_flag <= next_tx_buffer_full_flag;
        end
    end
endmodule : isam_status_flags

// [isam_top.sv]
// Purpose: Status flags and slave address mask of a two-wire bus controller.
// Assumes: AXI4-Lite register access; bus engine events are one-cycle pulses.
// Notes: One level interrupt gathers sticky events; reading the interrupt status clears it.
// Function
// - Start flag reads one when start or repeated start was the last condition.
// - Direction flag is one for slave read, zero for slave write.
// - Direction flag follows the read/write bit of the received address byte.
// - Receive full flag sets when a received byte enters the receive register.
// - Reading the receive register clears the receive full flag.
// - Writing the transmit register sets the transmit full flag.
// - Transmit full flag clears when the byte transmission completes.
// - Mask register holds ten bits reset to zero; upper bits read zero.
// - Mask bit one excludes that address bit from the match.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module isam_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [isam_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [isam_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [isam_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [isam_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [isam_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic start_det,
    input wire logic stop_det,
    input wire logic addr_byte_stb,
    input wire logic addr_rw,
    input wire logic rx_byte_stb,
    input wire logic [isam_pkg::BYTE_W-1:0] rx_byte,
    input wire logic tx_done,
    input wire logic addr_cmp_stb,
    input wire logic [isam_pkg::MASK_W-1:0] addr_cmp,
    output logic tx_load,
    output logic [isam_pkg::BYTE_W-1:0] tx_byte,
    output logic addr_match,
    output logic rx_buffer_full_flag,
    output logic tx_buffer_full_flag,
    output logic irq
);
    import isam_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [STRB_W-1:0] wr_strb;
    logic next_aw_got;
    logic next_w_got;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [DATA_W-1:0] next_wr_data;
    logic [STRB_W-1:0] next_wr_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [DATA_W-1:0] next_rdata;
    logic wr_fire;
    logic rd_fire;
    logic wr_hit;
    logic rd_hit;
    logic [MASK_W-1:0] address_bit_mask;
    logic [MASK_W-1:0] own_address;
    logic [BYTE_W-1:0] receive_data_register;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [MASK_W-1:0] next_address_bit_mask;
    logic [MASK_W-1:0] next_own_address;
    logic [BYTE_W-1:0] next_receive_data_register;
    logic [BYTE_W-1:0] next_tx_byte;
    logic next_tx_load;
    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] next_irq_mask;
    logic next_addr_match;
    logic [IRQ_W-1:0] irq_event;
    logic match_now;
    logic start_flag;
    logic read_write_flag;
    logic rx_read;
    logic tx_write;
    logic irq_read;
    logic [DATA_W-1:0] bus_status;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready = !w_got && !s_axi_bvalid;
    assign wr_fire = aw_got && w_got;

    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    assign wr_hit = (wr_addr == OFF_BUS_STATUS) || (wr_addr == OFF_SLAVE_ADDRESS_MASK)
        || (wr_addr == OFF_RECEIVE_DATA) || (wr_addr == OFF_TRANSMIT_DATA)
        || (wr_addr == OFF_OWN_ADDRESS) || (wr_addr == OFF_IRQ_STATUS)
        || (wr_addr == OFF_IRQ_MASK);

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_hit = (s_axi_araddr == OFF_BUS_STATUS)
        || (s_axi_araddr == OFF_SLAVE_ADDRESS_MASK)
        || (s_axi_araddr == OFF_RECEIVE_DATA) || (s_axi_araddr == OFF_TRANSMIT_DATA)
        || (s_axi_araddr == OFF_OWN_ADDRESS) || (s_axi_araddr == OFF_IRQ_STATUS)
        || (s_axi_araddr == OFF_IRQ_MASK);

    assign rx_read = rd_fire && (s_axi_araddr == OFF_RECEIVE_DATA);
    assign irq_read = rd_fire && (s_axi_araddr == OFF_IRQ_STATUS);

    always_comb begin
        bus_status = '0;
        bus_status[BIT_START] = start_flag;
        bus_status[BIT_READ_WRITE] = read_write_flag;
        bus_status[BIT_RX_FULL] = rx_buffer_full_flag;
        bus_status[BIT_TX_FULL] = tx_buffer_full_flag;
    end

    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFF_BUS_STATUS: next_rdata = bus_status;
                OFF_SLAVE_ADDRESS_MASK: next_rdata = {22'h000000, address_bit_mask};
                OFF_RECEIVE_DATA: next_rdata = {24'h000000, receive_data_register};
                OFF_TRANSMIT_DATA: next_rdata = {24'h000000, tx_byte};
                OFF_OWN_ADDRESS: next_rdata = {22'h000000, own_address};
                OFF_IRQ_STATUS: next_rdata = {27'h0000000, irq_status};
                OFF_IRQ_MASK: next_rdata = {27'h0000000, irq_mask};
                default: next_rdata = '0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Registers and data path
    // ------------------------------------------------------------------
    // Transmit write event.
    assign tx_write = wr_fire && (wr_addr == OFF_TRANSMIT_DATA) && wr_strb[0];

    always_comb begin
        next_address_bit_mask = address_bit_mask;
        next_own_address = own_address;
        next_tx_byte = tx_byte;
        next_tx_load = tx_write;
        next_receive_data_register = receive_data_register;
        next_irq_mask = irq_mask;
        next_addr_match = addr_cmp_stb && match_now;
        if (wr_fire && (wr_addr == OFF_SLAVE_ADDRESS_MASK)) begin
            if (wr_strb[0]) begin
                next_address_bit_mask[7:0] = wr_data[7:0];
            end
            if (wr_strb[1]) begin
                next_address_bit_mask[9:8] = wr_data[9:8];
            end
        end
        if (wr_fire && (wr_addr == OFF_OWN_ADDRESS)) begin
            if (wr_strb[0]) begin
                next_own_address[7:0] = wr_data[7:0];
            end
            if (wr_strb[1]) begin
                next_own_address[9:8] = wr_data[9:8];
            end
        end
        if (wr_fire && (wr_addr == OFF_IRQ_MASK) && wr_strb[0]) begin
            next_irq_mask = wr_data[IRQ_W-1:0];
        end
        if (tx_write) begin
            next_tx_byte = wr_data[7:0];
        end
        if (rx_byte_stb) begin
            next_receive_data_register = rx_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            address_bit_mask <= RST_MASK;
            own_address <= RST_OWN_ADDRESS;
            tx_byte <= RST_BYTE;
            tx_load <= 1'b0;
            receive_data_register <= RST_BYTE;
            irq_mask <= RST_IRQ;
            addr_match <= 1'b0;
        end else begin
            address_bit_mask <= next_address_bit_mask;
            own_address <= next_own_address;
            tx_byte <= next_tx_byte;
            tx_load <= next_tx_load;
            receive_data_register <= next_receive_data_register;
            irq_mask <= next_irq_mask;
            addr_match <= next_addr_match;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_event[IRQ_START] = start_det;
    assign irq_event[IRQ_STOP] = stop_det;
    assign irq_event[IRQ_RX] = rx_byte_stb;
    assign irq_event[IRQ_TX_DONE] = tx_done;
    assign irq_event[IRQ_MATCH] = addr_cmp_stb && match_now;

    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
        assign next_irq_status[i] = irq_event[i] | (irq_status[i] & !irq_read);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    isam_status_flags u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .start_det(start_det),
        .stop_det(stop_det),
        .addr_byte_stb(addr_byte_stb),
        .addr_rw(addr_rw),
        .rx_byte_stb(rx_byte_stb),
        .rx_read(rx_read),
        .tx_write(tx_write),
        .tx_done(tx_done),
        .start_flag(start_flag),
        .read_write_flag(read_write_flag),
        .rx_buffer_full_flag(rx_buffer_full_flag),
        .tx_buffer_full_flag(tx_buffer_full_flag)
    );

    isam_addr_match u_match (
        .incoming(addr_cmp),
        .own_address(own_address),
        .address_bit_mask(address_bit_mask),
        .match(match_now)
    );
endmodule : isam_top

// [isam_top_monitor.sv]
// Purpose: Port assertions for the status and mask block.
// Assumes: One clock domain; sees only the top module's ports.
// Notes: Bound into the top module.
`timescale 1ns/10ps
module isam_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [isam_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic rx_byte_stb,
    input wire logic tx_done,
    input wire logic addr_cmp_stb,
    input wire logic tx_load,
    input wire logic addr_match,
    input wire logic rx_buffer_full_flag,
    input wire logic tx_buffer_full_flag,
    input wire logic irq
);
    import isam_pkg::*;
    logic rx_rd;
    logic wr_both;
    assign rx_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFF_RECEIVE_DATA);
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // --------
    // Assertions
    // --------
    chk_rx_set: assert property (rx_byte_stb |=> rx_buffer_full_flag)
        else $error("Rx flag not set.");
    chk_rx_cause: assert property ($rose(rx_buffer_full_flag) |-> $past(rx_byte_stb))
        else $error("Rx flag rose alone.");
    chk_rx_clear: assert property (rx_rd && !rx_byte_stb |=> !rx_buffer_full_flag)
        else $error("Rx flag kept after read.");
    chk_rx_keep: assert property ($fell(rx_buffer_full_flag) |-> $past(rx_rd))
        else $error("Rx flag fell alone.");
    chk_tx_set: assert property (tx_load |-> tx_buffer_full_flag)
        else $error("Load without tx flag.");
    chk_tx_cause: assert property ($rose(tx_buffer_full_flag) |-> ##[0:1] tx_load)
        else $error("Tx flag rose alone.");
    chk_tx_clear: assert property (tx_done && s_axi_awready |=> !tx_buffer_full_flag)
        else $error("Tx flag kept.");
    chk_match_src: assert property (addr_match |-> $past(addr_cmp_stb))
        else $error("Match without compare.");
    chk_wr_latency: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("Write response late.");
    chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late.");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken while busy.");
    cover_rx_read: cover property (rx_rd && rx_buffer_full_flag);
    cover_match: cover property (addr_match);
    cover_tx_load: cover property (tx_load);
    cover_irq: cover property (irq);
endmodule : isam_top_monitor

bind isam_top isam_top_monitor isam_top_monitor_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rx_byte_stb, .tx_done, .addr_cmp_stb,
    .tx_load, .addr_match, .rx_buffer_full_flag, .tx_buffer_full_flag, .irq);
